//--- sim/flash_read_mode_config_test.sv
/*
 * Self-checking bench for the read front end: wrap setup, quad reads,
 * read parameters, quad-instruction mode, learning pattern, continuous.
 * Assumes the array answers one cycle after mem_addr moves.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) begin \
	comparisons++; \
	if ((gt) !== (ex)) begin \
		n_errors++; \
		$display("FAIL %s exp %h got %h", nm, ex, gt); \
	end \
end

module flash_read_mode_config_test import frmc_pkg::*; ;
	logic clk_sys, srst, quad_enable_bit, learning_pattern_enable;
	logic dummy_select_bit, addr4_mode, soft_reset;
	logic noise = 1'b0;
	logic [7:0] mem_data, got_byte, e;
	logic [15:0] seed = 16'h8215; // 33301
	wire logic sclk, cs_n, io_h_en, mem_rd, qim_active, cont_armed;
	wire logic [3:0] io_h, io_in, io_out, io_oe_n;
	wire logic [31:0] mem_addr;
	frmc_rdcfg_s read_cfg;
	int n_errors = 0, comparisons = 0, cyc = 0, drives = 0, drv0;
	logic [7:0] exp_q[$];
	event got_ev;

	// Undriven lines toggle so a stale value never passes
	assign io_in = (~io_oe_n & io_out) | (io_oe_n & (io_h_en ? io_h : {4{noise}}));

	frmc_top uut (.clk_sys(clk_sys), .srst(srst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n), .quad_enable_bit(quad_enable_bit),
		.learning_pattern_enable(learning_pattern_enable),
		.dummy_select_bit(dummy_select_bit), .addr4_mode(addr4_mode),
		.soft_reset(soft_reset), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data),
		.qim_active(qim_active), .cont_armed(cont_armed), .read_cfg(read_cfg));

	frmc_host host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .io_h(io_h),
		.io_h_en(io_h_en), .io_wire(io_in));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Array model with one-cycle latency, noise and drive watch
	always @(posedge clk_sys) begin
		// Array moves only on a read strobe, so a lost strobe shows as bad data
		if (mem_rd === 1'b1) mem_data <= mem_addr[7:0] ^ 8'h5A;
		noise <= ~noise;
		if (io_oe_n !== 4'hF) drives++;
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			stop_test();
		end
	end

	// Oldest expected byte against each byte seen
	always @(got_ev) begin
		e = exp_q.pop_front();
		`CHK("data", e, got_byte)
	end

	task automatic stop_test();
		if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	function automatic logic [31:0] rnd();
		logic [15:0] h;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		h = seed;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return {h, seed};
	endfunction : rnd

	// Standard quad read up to the end of the mode byte
	task automatic eb(input logic [31:0] a, input logic [7:0] m, input logic skip);
		host.start();
		if (!skip) host.cmd(CMD_QUAD_IO_READ, 1'b0);
		host.nibs(addr4_mode ? 8 : 6, a, 1'b0);
		host.nibs(2, {24'h0, m}, 1'b0);
	endtask : eb

	// Dummies with pattern check from slot p, then n bytes noted and caught
	task automatic rd(input logic [31:0] a, input int l, input logic wr, input int d,
		input int n, input logic ddr, input int p);
		logic [3:0] hi, lo;
		logic [31:0] x;
		for (int i = 0; i < d; i++) begin
			if (ddr) host.half(4'h0, 1'b0, hi);
			else host.sdr(4'h0, 1'b0, hi);
			if (learning_pattern_enable && i >= p && i < p + 8) begin
				`CHK("pattern", {4{LEARN_PAT[7-i+p]}}, hi)
			end
		end
		for (int k = 0; k < n; k++) begin
			x = wr ? ((a & ~(l - 1)) | ((a + k) & (l - 1))) : a + k;
			exp_q.push_back(x[7:0] ^ 8'h5A);
			if (ddr) begin
				host.half(4'h0, 1'b0, hi);
				host.half(4'h0, 1'b0, lo);
			end else begin
				host.sdr(4'h0, 1'b0, hi);
				host.sdr(4'h0, 1'b0, lo);
			end
			got_byte = {hi, lo};
			->got_ev;
		end
		// Odd edge count leaves the link clock high; bring it low first
		if (sclk) host.half(4'h0, 1'b0, hi);
		host.stop();
	endtask : rd

	// Main sequence
	initial begin
		int l;
		logic [31:0] a;
		frmc_rdcfg_s c;
		logic [5:0] dt [4];
		dt = '{DUM_CODE0, DUM_CODE1, DUM_CODE2, DUM_CODE3};
		srst = 1'b1;
		{quad_enable_bit, learning_pattern_enable, dummy_select_bit} = 3'h0;
		{addr4_mode, soft_reset} = 2'h0;
		repeat (10) @(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK("read_cfg", {1'b0, CFG_RST}, {qim_active, read_cfg})
		for (int k = 0; k < 4; k++) begin
			addr4_mode = k[0];
			dummy_select_bit = k[1];
			learning_pattern_enable = ~k[0];
			host.wrap_setup({1'b0, k[1:0], 5'h00}, addr4_mode);
			`CHK("wrap", {1'b0, k[1:0]}, {read_cfg.wrap_dis, read_cfg.wrap_size})
			l = 8 << k;
			a = (rnd() & ~(l - 1)) | (l - 2);
			eb(a, 8'h00, 1'b0);
			rd(a, l, 1'b1, dummy_select_bit ? 6 : 4, 4, 1'b0, 0);
		end
		addr4_mode = 1'b0;
		host.wrap_setup(8'h10, 1'b0);
		`CHK("wrap_dis", 1'b1, read_cfg.wrap_dis)
		a = rnd() | 32'hFE;
		eb(a, 8'h00, 1'b0);
		rd(a, 8, 1'b0, 6, 3, 1'b0, 0);
		c = read_cfg;
		drv0 = drives;
		host.start();
		host.cmd(CMD_READ_PARAM, 1'b0);
		host.nibs(2, 32'h33, 1'b0);
		host.stop();
		`CHK("param_std", {c, 1'b0}, {read_cfg, drives != drv0})
		host.one(CMD_QUAD_INSTR_ENTRY, 1'b0);
		`CHK("qim_off", 1'b0, qim_active)
		quad_enable_bit = 1'b1;
		host.one(CMD_QUAD_INSTR_ENTRY, 1'b0);
		`CHK("qim_on", {1'b1, c}, {qim_active, read_cfg})
		drv0 = drives;
		host.start();
		host.cmd(CMD_DDR_QUAD_READ_WIDE_ADDR, 1'b1);
		host.nibs(8, rnd(), 1'b0);
		host.idle(12);
		host.stop();
		`CHK("wide_qim", 1'b0, drives != drv0)
		learning_pattern_enable = 1'b1;
		for (int k = 0; k < 4; k++) begin
			host.start();
			host.cmd(CMD_READ_PARAM, 1'b1);
			host.nibs(2, {26'h0, k[1:0], 2'h0, k[1:0]}, 1'b0);
			host.stop();
			`CHK("param", {k[1:0], k[1:0]}, {read_cfg.dummy_cnt, read_cfg.wrap_len})
			l = 8 << k;
			a = (rnd() & ~(l - 1)) | (l - 1);
			host.start();
			host.cmd(CMD_WRAP_READ, 1'b1);
			host.nibs(6, a, 1'b0);
			rd(a, l, 1'b1, int'(dt[k]), 3, 1'b0, 0);
		end
		// DDR wrap read, 8 dummies as 16 edges: pattern in the last eight edges
		dummy_select_bit = 1'b0;
		a = (rnd() & ~32'h0000003F) | 32'h0000003E;
		host.start();
		host.cmd(CMD_DDR_WRAP_READ, 1'b1);
		host.nibs(6, a, 1'b1);
		rd(a, 64, 1'b1, 17, 3, 1'b1, 9);
		dummy_select_bit = 1'b1;
		host.one(CMD_QUAD_INSTR_EXIT, 1'b1);
		`CHK("qim_exit", {1'b0, c.wrap_dis, c.wrap_size}, {qim_active, read_cfg[7:5]})
		a = rnd();
		host.start();
		host.cmd(CMD_DDR_QUAD_READ_WIDE_ADDR, 1'b0);
		host.nibs(8, a, 1'b1);
		host.nibs(2, 32'h0, 1'b1);
		`CHK("wide_addr", a, mem_addr)
		host.idle(4);
		host.stop();
		a = rnd();
		eb(a, 8'h20, 1'b0);
		rd(a, 8, 1'b0, 6, 1, 1'b0, 0);
		`CHK("cont_on", 1'b1, cont_armed)
		a = rnd();
		eb(a, 8'h00, 1'b1);
		rd(a, 8, 1'b0, 6, 2, 1'b0, 0);
		`CHK("cont_off", 1'b0, cont_armed)
		soft_reset = 1'b1;
		@(posedge clk_sys);
		#1 soft_reset = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("soft_reset", CFG_RST, read_cfg)
		if (exp_q.size() != 0) n_errors++;
		stop_test();
	end
endmodule : flash_read_mode_config_test

`default_nettype wire

//--- sim/frmc_host.sv
/*
 * Host controller model: drives link clock, chip select and IO lines of
 * the read front end and samples whatever the device puts on the lines.
 * Assumes clk_sys at 100 MHz; one link half period is eight cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module frmc_host import frmc_pkg::*; (
	// Pacing clock
	input wire logic clk_sys,
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_h,
	output logic io_h_en,
	// Resolved line levels
	input wire logic [3:0] io_wire
);
	// Link clock stands low between frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_h = 4'h0;
		io_h_en = 1'b0;
	end

	// Data moves mid-half so either edge sees it settled
	task automatic half(input logic [3:0] v, input logic en, output logic [3:0] g);
		repeat (4) @(posedge clk_sys);
		#1 io_h = v;
		io_h_en = en;
		repeat (4) @(posedge clk_sys);
		#1 sclk = ~sclk;
		g = io_wire;
	endtask : half

	// One SDR clock, line caught at the rise
	task automatic sdr(input logic [3:0] v, input logic en, output logic [3:0] g);
		logic [3:0] x;
		half(v, en, g);
		half(v, en, x);
	endtask : sdr

	// Nibbles MSB first, per clock or per edge
	task automatic nibs(input int n, input logic [31:0] d, input logic ddr);
		logic [3:0] x;
		for (int i = n - 1; i >= 0; i--) begin
			if (ddr) half(d[4*i+:4], 1'b1, x);
			else sdr(d[4*i+:4], 1'b1, x);
		end
	endtask : nibs

	// Single line, MSB first
	task automatic bits(input int n, input logic [31:0] d);
		logic [3:0] x;
		for (int i = n - 1; i >= 0; i--) sdr({3'h0, d[i]}, 1'b1, x);
	endtask : bits

	// Released clocks
	task automatic idle(input int n);
		logic [3:0] x;
		repeat (n) sdr(4'h0, 1'b0, x);
	endtask : idle

	task automatic start();
		@(posedge clk_sys);
		#1 cs_n = 1'b0;
	endtask : start

	// Release lines with chip select; gap covers one link period
	task automatic stop();
		repeat (4) @(posedge clk_sys);
		#1 cs_n = 1'b1;
		io_h_en = 1'b0;
		repeat (24) @(posedge clk_sys);
		#1;
	endtask : stop

	task automatic cmd(input logic [7:0] op, input logic q);
		if (q) nibs(2, {24'h0, op}, 1'b0);
		else bits(8, {24'h0, op});
	endtask : cmd

	task automatic one(input logic [7:0] op, input logic q);
		start();
		cmd(op, q);
		stop();
	endtask : one

	// Opcode, 24 or 32 dummy bits, wrap byte
	task automatic wrap_setup(input logic [7:0] wb, input logic a4);
		start();
		bits(8, {24'h0, CMD_WRAP_SETUP});
		bits(a4 ? 32 : 24, 32'h0);
		bits(8, {24'h0, wb});
		stop();
	endtask : wrap_setup
endmodule : frmc_host

`default_nettype wire

//--- verilog/frmc_pin_sync.sv
/*
 * Two-stage synchroniser for the link pins plus one delay stage for edge
 * detection. Assumes the pins are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module frmc_pin_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Pins in, synchronised and delayed copies out
	input wire logic [W-1:0] din,
	output logic [W-1:0] sync,
	output logic [W-1:0] dly
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] dly_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_q <= RST;
			sync_q <= RST;
			dly_q <= RST;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			dly_q <= sync_q;
		end
	end

	assign sync = sync_q;
	assign dly = dly_q;

endmodule : frmc_pin_sync

`default_nettype wire

//--- verilog/frmc_pkg.sv
/*
 * Shared constants and types for the flash read-mode front end: opcodes,
 * phase lengths, dummy tables, read settings, sequencer state and resets.
 * Assumes a single system clock domain; lengths are counted in link edges.
 */
`default_nettype none

package frmc_pkg;

	// Opcodes handled by this block
	localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] CMD_DDR_QUAD_READ_WIDE_ADDR = 8'hEE;
	localparam logic [7:0] CMD_WRAP_SETUP = 8'h77;
	localparam logic [7:0] CMD_READ_PARAM = 8'hC0;
	localparam logic [7:0] CMD_WRAP_READ = 8'h0C;
	localparam logic [7:0] CMD_DDR_WRAP_READ = 8'h0E;
	localparam logic [7:0] CMD_QUAD_INSTR_ENTRY = 8'h38;
	localparam logic [7:0] CMD_QUAD_INSTR_EXIT = 8'hFF;

	// Phase lengths in sampling edges
	localparam logic [5:0] CMD_LEN_SPI = 6'h08;
	localparam logic [5:0] CMD_LEN_QIM = 6'h02;
	localparam logic [5:0] ADDR24_NIB = 6'h06;
	localparam logic [5:0] ADDR32_NIB = 6'h08;
	localparam logic [5:0] MODE_EDGES = 6'h02;
	localparam logic [5:0] WRAP_DUM24 = 6'h18;
	localparam logic [5:0] WRAP_DUM32 = 6'h20;
	localparam logic [5:0] WRAP_BYTE_BITS = 6'h08;
	localparam logic [5:0] PARAM_NIB = 6'h02;

	// Dummy clocks
	localparam logic [5:0] QIM_DUM_RST = 6'h02;
	localparam logic [5:0] DUM_CODE0 = 6'h0A;
	localparam logic [5:0] DUM_CODE1 = 6'h04;
	localparam logic [5:0] DUM_CODE2 = 6'h06;
	localparam logic [5:0] DUM_CODE3 = 6'h08;
	localparam logic [5:0] QREAD_DUM_DSEL0 = 6'h04;
	localparam logic [5:0] QREAD_DUM_DSEL1 = 6'h06;
	localparam logic [5:0] DDR_DUM_DSEL0 = 6'h08;
	localparam logic [5:0] DDR_DUM_DSEL1 = 6'h0A;

	// Learning pattern
	localparam logic [7:0] LEARN_PAT = 8'h34;
	localparam logic [5:0] PAT_BITS = 6'h08;
	localparam logic [5:0] PAT_DSEL_SHIFT = 6'h04;
	localparam logic [1:0] CONT_KEY = 2'h2;

	// Pin synchroniser reset: chip select idles high
	localparam logic [5:0] PIN_RST = 6'h10;

	typedef struct packed {
		logic wrap_dis;
		logic [1:0] wrap_size;
		logic dummy_prog;
		logic [1:0] dummy_cnt;
		logic [1:0] wrap_len;
	} frmc_rdcfg_s;

	localparam frmc_rdcfg_s CFG_RST = '{wrap_dis: 1'b1, default: '0};

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CMD = 4'h1,
		ST_ADDR = 4'h2,
		ST_MODE = 4'h3,
		ST_DUM = 4'h4,
		ST_DATA = 4'h5,
		ST_WDUM = 4'h6,
		ST_WBYTE = 4'h7,
		ST_PARM = 4'h8,
		ST_IGN = 4'h9
	} frmc_state_e;

	typedef struct packed {
		logic ok;
		logic ddr;
		logic [5:0] alen;
		logic [5:0] mlen;
		logic [5:0] dlim;
		logic [5:0] pst;
		logic wrap_on;
		logic [1:0] wsel;
	} frmc_plan_s;

	typedef struct packed {
		frmc_state_e st;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [7:0] cmd;
		logic quad;
		logic ddr;
		logic [5:0] mlen;
		logic wrap_on;
		logic [1:0] wsel;
		logic [5:0] dlim;
		logic [5:0] pst;
		logic [5:0] tick;
		logic nib;
		logic [3:0] lo;
		logic qim;
		logic cont;
		frmc_rdcfg_s cfg;
		logic [31:0] addr;
		logic rd;
		logic [3:0] dout;
		logic [3:0] oe_n;
	} frmc_seq_s;

	localparam frmc_seq_s SEQ_RST = '{st: ST_IDLE, oe_n: 4'hF, cfg: CFG_RST, default: '0};

endpackage : frmc_pkg

`default_nettype wire

//--- verilog/frmc_top.sv
/*
 * Flash read-mode front end: command decode for quad and DDR reads, wrap
 * setup, read parameters, quad-instruction mode and the learning pattern.
 * Assumes an array read port on clk_sys answering one cycle after mem_addr
 * moves, and a link clock far slower than clk_sys (eight cycles per half).
 */
// Behaviour
// - wide-address DDR quad read always takes 32 address bits
// - wide-address DDR quad read refused in quad-instruction mode
// - wrap size bits pick 8..64 bytes unless disabled
// - standard-mode quad reads wrap inside the page section
// - wrap disable resets to one, cleared only by setup
// - read parameter command only taken in quad-instruction mode
// - dummy count field maps to 10, 4, 6, 8
// - wrap length field maps to 8..64 bytes
// - reset gives 8-byte wrap length and 2 dummies
// - SDR wrap read wraps at parameter section boundary
// - DDR wrap read wraps at parameter section boundary
// - pattern enable drives learning pattern during dummies
// - pattern follows continuous mode bits, never replaces them
// - SDR pattern starts after mode bits, excess cut
// - DDR pattern fills the last four dummy clocks
// - DDR with dummy select outputs pattern bits 7..4
// - DDR quad with dummy select delays pattern two clocks
// - entry opcode works only with quad enable set
// - exit opcode returns to standard instruction mode
// - mode switch leaves wrap settings untouched
// - mode bits 10 skip the next opcode
`timescale 1ns/100ps
`default_nettype none

module frmc_top import frmc_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	// Configuration bits
	input wire logic quad_enable_bit,
	input wire logic learning_pattern_enable,
	input wire logic dummy_select_bit,
	input wire logic addr4_mode,
	input wire logic soft_reset,
	// Array read port
	output logic [31:0] mem_addr,
	output logic mem_rd,
	input wire logic [7:0] mem_data,
	// Status
	output logic qim_active,
	output logic cont_armed,
	output frmc_rdcfg_s read_cfg
);

	frmc_seq_s seq_q;
	frmc_seq_s seq_d;
	frmc_plan_s plan;
	logic [5:0] sync_w;
	logic [5:0] dly_w;
	logic go_addr;
	logic emit;

	// Read plan for one opcode under the current mode and settings
	function automatic frmc_plan_s plan_f(input logic [7:0] c, input logic qim,
		input logic a4, input logic dsel, input frmc_rdcfg_s g);
		frmc_plan_s p;
		logic [5:0] qd;
		logic [5:0] dd;
		p = '0;
		case (g.dummy_cnt)
			2'h0: qd = DUM_CODE0;
			2'h1: qd = DUM_CODE1;
			2'h2: qd = DUM_CODE2;
			default: qd = DUM_CODE3;
		endcase
		if (!g.dummy_prog) begin
			qd = QIM_DUM_RST;
		end
		dd = dsel ? DDR_DUM_DSEL1 : DDR_DUM_DSEL0;
		p.alen = a4 ? ADDR32_NIB : ADDR24_NIB;
		case (c)
			CMD_QUAD_IO_READ: begin
				p.ok = 1'b1;
				p.mlen = MODE_EDGES;
				p.wrap_on = !qim && !g.wrap_dis;
				p.wsel = g.wrap_size;
				if (qim) begin
					p.dlim = (qd > MODE_EDGES) ? qd - MODE_EDGES : 6'h00;
				end else begin
					p.dlim = dsel ? QREAD_DUM_DSEL1 : QREAD_DUM_DSEL0;
				end
			end
			CMD_DDR_QUAD_READ_WIDE_ADDR: begin
				p.ok = !qim;
				p.ddr = 1'b1;
				p.alen = ADDR32_NIB;
				p.mlen = MODE_EDGES;
				p.dlim = {dd[4:0], 1'b0};
				p.wrap_on = !g.wrap_dis;
				p.wsel = g.wrap_size;
			end
			CMD_WRAP_READ: begin
				p.ok = qim;
				p.dlim = qd;
				p.wrap_on = 1'b1;
				p.wsel = g.wrap_len;
			end
			CMD_DDR_WRAP_READ: begin
				p.ok = qim;
				p.ddr = 1'b1;
				p.dlim = {qd[4:0], 1'b0};
				p.wrap_on = 1'b1;
				p.wsel = g.wrap_len;
			end
			default: begin
				p.ok = 1'b0;
			end
		endcase
		// Pattern start edge: last four clocks for DDR, moved on by dummy select
		if (p.ddr) begin
			p.pst = ((p.dlim >= PAT_BITS) ? p.dlim - PAT_BITS : 6'h00)
				+ (dsel ? PAT_DSEL_SHIFT : 6'h00);
		end
		return p;
	endfunction : plan_f

	// Link pins pass two flip-flops before anything looks at them
	frmc_pin_sync #(.W(6), .RST(PIN_RST)) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.din({sclk, cs_n, io_in}),
		.sync(sync_w),
		.dly(dly_w)
	);

	// Edge and strobe decode
	wire sclk_rise = sync_w[5] && !dly_w[5];
	wire sclk_fall = !sync_w[5] && dly_w[5];
	wire cs_rise = sync_w[4] && !dly_w[4];
	wire cs_fall = !sync_w[4] && dly_w[4];
	wire [3:0] s_io = sync_w[3:0];
	wire in_edge = sclk_rise || (seq_q.ddr && sclk_fall);
	wire out_edge = sclk_fall || (seq_q.ddr && sclk_rise);
	wire last_in = in_edge && (seq_q.cnt == 6'h01);
	wire [5:0] cnt_dec = seq_q.cnt - 6'h01;

	// Shift in one bit, or a nibble once the lines are quad
	wire [31:0] shin = seq_q.quad ? {seq_q.sh[27:0], s_io} : {seq_q.sh[30:0], s_io[0]};
	wire [7:0] cmd_in = shin[7:0];
	wire cmd_done = (seq_q.st == ST_CMD) && last_in && !cs_rise && !cs_fall;
	wire [7:0] plan_cmd = (seq_q.st == ST_CMD) ? cmd_in : seq_q.cmd;
	wire entry_ok = (cmd_in == CMD_QUAD_INSTR_ENTRY) && !seq_q.qim && quad_enable_bit;
	wire exit_ok = (cmd_in == CMD_QUAD_INSTR_EXIT) && seq_q.qim;

	assign plan = plan_f(plan_cmd, seq_q.qim, addr4_mode, dummy_select_bit, seq_q.cfg);

	// Wrapped address step; sections are aligned inside a 256-byte page
	wire [31:0] wmask = {24'h000000, (8'h08 << seq_q.wsel) - 8'h01};
	wire [31:0] addr_inc = seq_q.addr + 32'h00000001;
	wire [31:0] addr_nxt = seq_q.wrap_on ?
		((seq_q.addr & ~wmask) | (addr_inc & wmask)) : addr_inc;

	// Learning pattern slot for the current dummy edge
	wire [5:0] pidx = seq_q.tick - seq_q.pst;
	wire pat_on = learning_pattern_enable && (seq_q.tick >= seq_q.pst)
		&& (pidx < PAT_BITS);
	wire pat_bit = LEARN_PAT[~pidx[2:0]];

	// Sequencer next state
	always_comb begin
		seq_d = seq_q;
		go_addr = 1'b0;
		emit = 1'b0;
		seq_d.rd = 1'b0;
		if (soft_reset) begin
			seq_d.cfg = CFG_RST;
		end
		if (cs_rise) begin
			seq_d.st = ST_IDLE;
			seq_d.oe_n = 4'hF;
		end else if (cs_fall) begin
			seq_d.st = ST_CMD;
			seq_d.tick = 6'h00;
			seq_d.nib = 1'b0;
			seq_d.ddr = 1'b0;
			seq_d.quad = seq_q.qim;
			seq_d.cnt = seq_q.qim ? CMD_LEN_QIM : CMD_LEN_SPI;
			go_addr = seq_q.cont && plan.ok;
		end else begin
			case (seq_q.st)
				ST_CMD: begin
					if (in_edge) begin
						seq_d.sh = shin;
						seq_d.cnt = cnt_dec;
					end
					if (cmd_done) begin
						seq_d.cmd = cmd_in;
						seq_d.st = ST_IGN;
						if (plan.ok) begin
							go_addr = 1'b1;
						end else if (cmd_in == CMD_WRAP_SETUP && !seq_q.qim) begin
							seq_d.st = ST_WDUM;
							seq_d.cnt = addr4_mode ? WRAP_DUM32 : WRAP_DUM24;
						end else if (cmd_in == CMD_READ_PARAM && seq_q.qim) begin
							seq_d.st = ST_PARM;
							seq_d.cnt = PARAM_NIB;
						end else if (entry_ok) begin
							seq_d.qim = 1'b1;
						end else if (exit_ok) begin
							seq_d.qim = 1'b0;
						end
					end
				end
				ST_ADDR: begin
					// Double rate opens on the first address rise, so the
					// opcode's closing fall is never taken as a nibble
					if (sclk_rise) begin
						seq_d.ddr = plan.ddr;
					end
					if (in_edge) begin
						seq_d.sh = shin;
						seq_d.cnt = cnt_dec;
					end
					if (last_in) begin
						seq_d.addr = (plan.alen == ADDR32_NIB) ? shin : {8'h00, shin[23:0]};
						seq_d.rd = 1'b1;
						seq_d.cnt = seq_q.mlen;
						seq_d.st = (seq_q.mlen != 6'h00) ? ST_MODE : ST_DUM;
					end
				end
				ST_MODE: begin
					if (in_edge) begin
						seq_d.sh = shin;
						seq_d.cnt = cnt_dec;
					end
					if (last_in) begin
						seq_d.cont = (shin[5:4] == CONT_KEY);
						seq_d.st = ST_DUM;
					end
				end
				ST_DUM: begin
					if (out_edge && seq_q.tick < seq_q.dlim) begin
						seq_d.tick = seq_q.tick + 6'h01;
						seq_d.dout = {4{pat_bit}};
						seq_d.oe_n = pat_on ? 4'h0 : 4'hF;
					end else if (out_edge) begin
						seq_d.st = ST_DATA;
						emit = 1'b1;
					end
				end
				ST_DATA: begin
					emit = out_edge;
				end
				ST_WDUM: begin
					if (in_edge) begin
						seq_d.cnt = cnt_dec;
					end
					if (last_in) begin
						seq_d.st = ST_WBYTE;
						seq_d.cnt = WRAP_BYTE_BITS;
					end
				end
				ST_WBYTE: begin
					if (in_edge) begin
						seq_d.sh = shin;
						seq_d.cnt = cnt_dec;
					end
					if (last_in) begin
						seq_d.cfg.wrap_dis = shin[4];
						seq_d.cfg.wrap_size = shin[6:5];
						seq_d.st = ST_IGN;
					end
				end
				ST_PARM: begin
					if (in_edge) begin
						seq_d.sh = shin;
						seq_d.cnt = cnt_dec;
					end
					if (last_in) begin
						seq_d.cfg.dummy_cnt = shin[5:4];
						seq_d.cfg.wrap_len = shin[1:0];
						seq_d.cfg.dummy_prog = 1'b1;
						seq_d.st = ST_IGN;
					end
				end
				default: begin
					seq_d.st = seq_q.st;
				end
			endcase
		end
		// Load a read plan; a continuous restart reuses the held opcode
		if (go_addr) begin
			seq_d.st = ST_ADDR;
			seq_d.quad = 1'b1;
			seq_d.ddr = 1'b0; // Opened at the first address rise
			seq_d.cnt = plan.alen;
			seq_d.mlen = plan.mlen;
			seq_d.dlim = plan.dlim;
			seq_d.pst = plan.pst;
			seq_d.wrap_on = plan.wrap_on;
			seq_d.wsel = plan.wsel;
		end
		// One nibble per output edge; the low half is held, not refetched
		if (emit) begin
			seq_d.oe_n = 4'h0;
			seq_d.nib = !seq_q.nib;
			if (!seq_q.nib) begin
				seq_d.dout = mem_data[7:4];
				seq_d.lo = mem_data[3:0];
				seq_d.addr = addr_nxt;
				seq_d.rd = 1'b1;
			end else begin
				seq_d.dout = seq_q.lo;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			seq_q <= SEQ_RST;
		end else begin
			seq_q <= seq_d;
		end
	end

	// Outputs straight from the state register
	assign io_out = seq_q.dout;
	assign io_oe_n = seq_q.oe_n;
	assign mem_addr = seq_q.addr;
	assign mem_rd = seq_q.rd;
	assign qim_active = seq_q.qim;
	assign cont_armed = seq_q.cont;
	assign read_cfg = seq_q.cfg;

	// Checks on the sequencer
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	ee_refuse_a: assert property (cmd_done && cmd_in == CMD_DDR_QUAD_READ_WIDE_ADDR
		&& seq_q.qim |=> seq_q.st == ST_IGN) else $error("wide DDR read taken in quad mode");
	ee_addr32_a: assert property (cmd_done && cmd_in == CMD_DDR_QUAD_READ_WIDE_ADDR
		&& !seq_q.qim |=> seq_q.st == ST_ADDR && seq_q.cnt == ADDR32_NIB && plan.ddr)
		else $error("wide DDR read not set for 32-bit address");
	param_refuse_a: assert property (cmd_done && cmd_in == CMD_READ_PARAM && !seq_q.qim
		|=> seq_q.st == ST_IGN ##1 $stable(seq_q.cfg))
		else $error("read parameter taken in standard mode");
	entry_gate_a: assert property (cmd_done && cmd_in == CMD_QUAD_INSTR_ENTRY
		&& !seq_q.qim |=> seq_q.qim == $past(quad_enable_bit))
		else $error("quad entry not gated by quad enable");
	exit_mode_a: assert property (cmd_done && cmd_in == CMD_QUAD_INSTR_EXIT && seq_q.qim
		|=> !seq_q.qim) else $error("quad exit ignored");
	mode_keep_a: assert property ($changed(seq_q.qim) && !$past(soft_reset)
		|-> $stable(seq_q.cfg)) else $error("mode switch altered wrap settings");
	reset_dflt_a: assert property (soft_reset && !in_edge |=> seq_q.cfg == CFG_RST)
		else $error("reset did not restore read defaults");
	wrap_hold_a: assert property (seq_q.wrap_on && seq_q.st == ST_DATA && $changed(seq_q.addr)
		|-> ((seq_q.addr ^ $past(seq_q.addr)) & ~wmask) == 32'h00000000)
		else $error("wrap moved upper address bits");
	pat_first_a: assert property (seq_q.st == ST_DUM && out_edge && !cs_rise
		&& learning_pattern_enable && seq_q.pst == 6'h00 && seq_q.tick == 6'h00
		&& seq_q.dlim != 6'h00 |=> seq_q.dout == {4{LEARN_PAT[7]}} && seq_q.oe_n == 4'h0)
		else $error("pattern first bit wrong");
	ddr_start_a: assert property (seq_q.st == ST_ADDR && seq_q.ddr && seq_q.dlim >= PAT_BITS
		|-> seq_q.pst == seq_q.dlim - PAT_BITS + (dummy_select_bit ? PAT_DSEL_SHIFT : 6'h00))
		else $error("DDR pattern start misplaced");
	cont_skip_a: assert property (cs_fall && seq_q.cont && plan.ok |=> seq_q.st == ST_ADDR)
		else $error("continuous read did not skip opcode");

	qim_entry_c: cover property (cmd_done && entry_ok);
	wrap_roll_c: cover property (seq_q.wrap_on && emit && addr_inc[5:0] == 6'h00);
	pat_drive_c: cover property (seq_q.st == ST_DUM && seq_q.oe_n == 4'h0);
	cont_go_c: cover property (cs_fall && seq_q.cont && plan.ok);

endmodule : frmc_top

`default_nettype wire
